// *** verilog/pevc_consts.svh ***
// offsets, field positions, reset values and timing counts of the enable/address/reference block
`ifndef PEVC_CONSTS_SVH
`define PEVC_CONSTS_SVH

// register indices, byte address is four times the index
`define PEVC_IDX_OPERATION   10'h001
`define PEVC_IDX_ON_OFF      10'h002
`define PEVC_IDX_VOLTAGE_FORMAT_QUERY   10'h020
`define PEVC_IDX_TRIM        10'h040
`define PEVC_IDX_MRG_HIGH    10'h041
`define PEVC_IDX_MRG_LOW     10'h042
`define PEVC_IDX_STATUS      10'h043

// reset values
`define PEVC_RST_OPERATION   8'h00
`define PEVC_RST_ON_OFF      8'h16
`define PEVC_RST_TRIM        16'h0000
`define PEVC_RST_MRG_HIGH    16'h0000
`define PEVC_RST_MRG_LOW     16'h0000
`define PEVC_VOLTAGE_FORMAT_QUERY_VAL   8'h17

// field positions
`define PEVC_OP_ON_BIT       7
`define PEVC_OP_MRG_HI       5
`define PEVC_OP_MRG_LO       4
`define PEVC_CFG_CMD_BIT     3
`define PEVC_CFG_PIN_BIT     2
`define PEVC_CFG_POL_BIT     1
`define PEVC_LIN11_EXP_HI    15
`define PEVC_LIN11_EXP_LO    11
`define PEVC_LIN11_MANT_HI   10

// address straps
`define PEVC_ADDR_FALLBACK   7'h7f
`define PEVC_DIGIT_MAX       4'h7

// reference arithmetic in millivolts
`define PEVC_VREF_NOM_MV     600
`define PEVC_MV_PER_VOLT     1000
`define PEVC_TRIM_EXP        (-9)
`define PEVC_TRIM_LO_PCT     20
`define PEVC_TRIM_HI_PCT     10
`define PEVC_SUM_LO_PCT      30
`define PEVC_SUM_HI_PCT      10
`define PEVC_TRIM_STEP_MV    2

// timing
`define PEVC_CLK_PERIOD_NS   8
`define PEVC_STD_BIT_NS      10000
`define PEVC_FAST_BIT_NS     2500
`define PEVC_STD_BIT_CYC     (`PEVC_STD_BIT_NS / `PEVC_CLK_PERIOD_NS)
`define PEVC_FAST_BIT_CYC    (`PEVC_FAST_BIT_NS / `PEVC_CLK_PERIOD_NS)
`define PEVC_MIN_OVERSAMPLE  8

`endif

// *** verilog/pevc_pkg.sv ***
// types of the enable/address/reference block
package pevc_pkg;

  typedef enum logic [1:0] {
    pevc_mrg_none,
    pevc_mrg_low,
    pevc_mrg_high
  } pevc_margin_t;

  typedef enum logic [1:0] {
    pevc_ctl_always,
    pevc_ctl_pin_only,
    pevc_ctl_cmd_only,
    pevc_ctl_both
  } pevc_ctl_mode_t;

endpackage

// *** verilog/pevc_addr_decode.sv ***
// bus address from two octal straps, caught once after reset
`timescale 1ns/1ps
`include "pevc_consts.svh"
module pevc_addr_decode (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // straps
  input  wire logic [3:0] addr_strap_low_digit,
  input  wire logic [3:0] addr_strap_high_digit,
  // result
  output logic      [6:0] bus_address_q,
  output logic            strap_valid_q,
  output logic            strap_done_q
);

  logic ok;
  assign ok = (addr_strap_low_digit <= `PEVC_DIGIT_MAX) && (addr_strap_high_digit <= `PEVC_DIGIT_MAX);

  // straps sampled at the first edge after reset release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_address_q <= `PEVC_ADDR_FALLBACK;
      strap_valid_q <= 1'b0;
      strap_done_q  <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q  <= 1'b1;
      strap_valid_q <= ok;
      if (ok) begin
        bus_address_q <= {1'b0, addr_strap_high_digit[2:0], addr_strap_low_digit[2:0]}; // [R5] [R6]
      end else begin
        bus_address_q <= `PEVC_ADDR_FALLBACK; // [R7]
      end
    end
  end

  property p_addr_pack;
    @(posedge clk) disable iff (!arst_n)
      ($rose(strap_done_q) && $past(ok)) |-> (bus_address_q == {1'b0, $past(addr_strap_high_digit[2:0]),
                                                                $past(addr_strap_low_digit[2:0])});
  endproperty
  a_addr_pack: assert property (p_addr_pack) else $error("strap address not high*8+low"); // [R6]

  property p_addr_fallback;
    @(posedge clk) disable iff (!arst_n)
      ($rose(strap_done_q) && !$past(ok)) |-> (bus_address_q == 7'h7f) && !strap_valid_q;
  endproperty
  a_addr_fallback: assert property (p_addr_fallback) else $error("bad strap did not give 127"); // [R7]

endmodule

// *** verilog/pevc_vref_calc.sv ***
// feedback reference from trim and margin, clamped
`timescale 1ns/1ps
`include "pevc_consts.svh"
module pevc_vref_calc (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // settings
  input  wire logic [15:0]         trim_word,
  input  wire logic [15:0]         mrg_high_word,
  input  wire logic [15:0]         mrg_low_word,
  input  wire pevc_pkg::pevc_margin_t margin,
  // result
  output logic      [15:0]         ref_mv_q,
  output logic                     clamp_hit_q
);

  localparam logic signed [47:0] TRIM_LO = -48'(`PEVC_VREF_NOM_MV * `PEVC_TRIM_LO_PCT / 100);
  localparam logic signed [47:0] TRIM_HI = 48'(`PEVC_VREF_NOM_MV * `PEVC_TRIM_HI_PCT / 100);
  localparam logic signed [47:0] SUM_LO  = -48'(`PEVC_VREF_NOM_MV * `PEVC_SUM_LO_PCT / 100);
  localparam logic signed [47:0] SUM_HI  = 48'(`PEVC_VREF_NOM_MV * `PEVC_SUM_HI_PCT / 100);
  localparam logic signed [47:0] NOM_MV  = 48'(`PEVC_VREF_NOM_MV);
  localparam logic signed [47:0] STEP_MV = 48'(`PEVC_TRIM_STEP_MV);

  // mantissa times two to the exponent, in millivolts
  function automatic logic signed [47:0] lin_to_mv(input logic signed [15:0] mant,
                                                  input logic signed [4:0]  expo);
    logic signed [47:0] p;
    p = 48'(mant) * 48'(`PEVC_MV_PER_VOLT); // [R9]
    if (expo < 0) begin
      lin_to_mv = p >>> (-expo);
    end else begin
      lin_to_mv = p <<< expo;
    end
  endfunction

  function automatic logic signed [47:0] clamp(input logic signed [47:0] v,
                                              input logic signed [47:0] lo,
                                              input logic signed [47:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  logic signed [47:0] trim_raw, trim_mv, mrg_mv, sum_mv, sum_cl;

  always_comb begin
    trim_raw = lin_to_mv(trim_word, 5'(`PEVC_TRIM_EXP));
    trim_mv  = clamp(trim_raw, TRIM_LO, TRIM_HI); // [R10]
    trim_mv  = trim_mv - (trim_mv % STEP_MV); // [R11]
    case (margin)
      pevc_pkg::pevc_mrg_high: mrg_mv = lin_to_mv(16'($signed(mrg_high_word[10:0])),
                                                  mrg_high_word[15:11]); // [R14]
      pevc_pkg::pevc_mrg_low:  mrg_mv = lin_to_mv(16'($signed(mrg_low_word[10:0])),
                                                  mrg_low_word[15:11]); // [R15]
      default:                 mrg_mv = '0; // [R19]
    endcase
    sum_mv = mrg_mv + trim_mv;
    sum_cl = clamp(sum_mv, SUM_LO, SUM_HI); // [R12]
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_mv_q    <= 16'(`PEVC_VREF_NOM_MV);
      clamp_hit_q <= 1'b0;
    end else begin
      ref_mv_q    <= 16'(NOM_MV + sum_cl); // [R14] [R15] [R19]
      clamp_hit_q <= (sum_cl != sum_mv);
    end
  end

  property p_ref_range;
    @(posedge clk) disable iff (!arst_n)
      (ref_mv_q >= 16'd420) && (ref_mv_q <= 16'd660);
  endproperty
  a_ref_range: assert property (p_ref_range) else $error("reference outside clamp window"); // [R12]

  property p_nomargin_even;
    @(posedge clk) disable iff (!arst_n)
      (margin == pevc_pkg::pevc_mrg_none) |=> (ref_mv_q[0] == 1'b0) && (ref_mv_q >= 16'd480);
  endproperty
  a_nomargin_even: assert property (p_nomargin_even) else $error("trim not 2 mV stepped or in range"); // [R11]

endmodule

// *** verilog/pevc_top.sv ***
// apb registers, regulation enable, address straps and feedback reference
// Operation
// R1: pin-only mode follows control pin alone
// R2: control pin polarity is programmable
// R3: command-only mode follows operation command alone
// R4: combined mode needs pin and command on
// R5: address from two octal strap digits
// R6: high strap times eight plus low strap
// R7: bad strap gives fixed address 127
// R8: bus logic works at 100 and 400 kHz
// R9: numeric arguments are linear mantissa times 2^exp
// R10: trim spans -20% to +10% nominal
// R11: trim applied in 2 mV steps
// R12: margin plus trim clamped -30% to +10%
// R13: operation selects none, high or low margin
// R14: margin high adds high step, trim, 0.6V
// R15: margin low adds low step, trim, 0.6V
// R16: voltage format query read-only, exponent -9
// R17: operation is one byte at code 01h
// R18: on/off config is one byte at 02h
// R19: no margin gives trim plus 0.6V
`timescale 1ns/1ps
`include "pevc_consts.svh"
module pevc_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  // pins
  input  wire logic        enable_pin,
  input  wire logic [3:0]  addr_strap_low_digit,
  input  wire logic [3:0]  addr_strap_high_digit,
  // to the regulator and bus interface
  output logic             regulate_en_q,
  output logic      [15:0] feedback_node_ref_mv,
  output logic      [6:0]  bus_address,
  output logic             bus_fast_ok
);

  logic [7:0]  operation_q;
  logic [7:0]  on_off_q;
  logic [15:0] trim_q;
  logic [15:0] mrg_high_q;
  logic [15:0] mrg_low_q;
  logic [31:0] prdata_q;
  logic        strap_valid;
  logic        strap_done;
  logic        clamp_hit;
  logic        pin_on;
  logic        cmd_on;
  logic        en_d;
  pevc_pkg::pevc_margin_t   margin;
  pevc_pkg::pevc_ctl_mode_t mode;

  // word index match on an aligned address
  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    hit = (a[1:0] == 2'b00) && (a[11:2] == idx);
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, `PEVC_IDX_OPERATION) || hit(a, `PEVC_IDX_ON_OFF) || hit(a, `PEVC_IDX_VOLTAGE_FORMAT_QUERY) ||
             hit(a, `PEVC_IDX_TRIM) || hit(a, `PEVC_IDX_MRG_HIGH) || hit(a, `PEVC_IDX_MRG_LOW) ||
             hit(a, `PEVC_IDX_STATUS);
  endfunction

  logic wr_en;
  logic rd_setup;
  assign wr_en    = psel && penable && pwrite && mapped(paddr);
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped(paddr);
  assign prdata   = prdata_q;

  // command-side byte registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      operation_q <= `PEVC_RST_OPERATION;
      on_off_q    <= `PEVC_RST_ON_OFF;
    end else begin
      if (wr_en && pstrb[0] && hit(paddr, `PEVC_IDX_OPERATION)) begin
        operation_q <= pwdata[7:0]; // [R17]
      end
      if (wr_en && pstrb[0] && hit(paddr, `PEVC_IDX_ON_OFF)) begin
        on_off_q <= pwdata[7:0]; // [R18]
      end
    end
  end

  // linear-format word registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trim_q     <= `PEVC_RST_TRIM;
      mrg_high_q <= `PEVC_RST_MRG_HIGH;
      mrg_low_q  <= `PEVC_RST_MRG_LOW;
    end else if (wr_en) begin
      if (hit(paddr, `PEVC_IDX_TRIM)) begin
        if (pstrb[0]) trim_q[7:0] <= pwdata[7:0];
        if (pstrb[1]) trim_q[15:8] <= pwdata[15:8];
      end
      if (hit(paddr, `PEVC_IDX_MRG_HIGH)) begin
        if (pstrb[0]) mrg_high_q[7:0] <= pwdata[7:0];
        if (pstrb[1]) mrg_high_q[15:8] <= pwdata[15:8];
      end
      if (hit(paddr, `PEVC_IDX_MRG_LOW)) begin
        if (pstrb[0]) mrg_low_q[7:0] <= pwdata[7:0];
        if (pstrb[1]) mrg_low_q[15:8] <= pwdata[15:8];
      end
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (1'b1)
        hit(paddr, `PEVC_IDX_OPERATION): prdata_q <= {24'h00_0000, operation_q};
        hit(paddr, `PEVC_IDX_ON_OFF):    prdata_q <= {24'h00_0000, on_off_q};
        hit(paddr, `PEVC_IDX_VOLTAGE_FORMAT_QUERY): prdata_q <= {24'h00_0000, `PEVC_VOLTAGE_FORMAT_QUERY_VAL}; // [R16]
        hit(paddr, `PEVC_IDX_TRIM):      prdata_q <= {16'h0000, trim_q};
        hit(paddr, `PEVC_IDX_MRG_HIGH):  prdata_q <= {16'h0000, mrg_high_q};
        hit(paddr, `PEVC_IDX_MRG_LOW):   prdata_q <= {16'h0000, mrg_low_q};
        hit(paddr, `PEVC_IDX_STATUS):    prdata_q <= {feedback_node_ref_mv, 2'b00, bus_fast_ok, clamp_hit,
                                                      strap_valid, regulate_en_q, bus_address, 3'b000};
        default:                         prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // control mode and margin decode
  always_comb begin
    case ({on_off_q[`PEVC_CFG_CMD_BIT], on_off_q[`PEVC_CFG_PIN_BIT]})
      2'b01:   mode = pevc_pkg::pevc_ctl_pin_only;
      2'b10:   mode = pevc_pkg::pevc_ctl_cmd_only;
      2'b11:   mode = pevc_pkg::pevc_ctl_both;
      default: mode = pevc_pkg::pevc_ctl_always;
    endcase
    case ({operation_q[`PEVC_OP_MRG_HI], operation_q[`PEVC_OP_MRG_LO]})
      2'b10:   margin = pevc_pkg::pevc_mrg_high; // [R13]
      2'b01:   margin = pevc_pkg::pevc_mrg_low; // [R13]
      default: margin = pevc_pkg::pevc_mrg_none; // [R13]
    endcase
  end

  assign pin_on = (enable_pin == on_off_q[`PEVC_CFG_POL_BIT]); // [R2]
  assign cmd_on = operation_q[`PEVC_OP_ON_BIT];

  always_comb begin
    case (mode)
      pevc_pkg::pevc_ctl_pin_only: en_d = pin_on; // [R1]
      pevc_pkg::pevc_ctl_cmd_only: en_d = cmd_on; // [R3]
      pevc_pkg::pevc_ctl_both:     en_d = pin_on && cmd_on; // [R4]
      default:                     en_d = 1'b1;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regulate_en_q <= 1'b0;
    end else begin
      regulate_en_q <= en_d && strap_done;
    end
  end

  // clock must oversample a fast-mode bit
  assign bus_fast_ok = (`PEVC_FAST_BIT_CYC >= `PEVC_MIN_OVERSAMPLE) &&
                       (`PEVC_STD_BIT_CYC >= `PEVC_MIN_OVERSAMPLE); // [R8]

  pevc_addr_decode u_addr (
    .clk                   (clk),
    .arst_n                (arst_n),
    .addr_strap_low_digit  (addr_strap_low_digit),
    .addr_strap_high_digit (addr_strap_high_digit),
    .bus_address_q         (bus_address),
    .strap_valid_q         (strap_valid),
    .strap_done_q          (strap_done)
  );

  pevc_vref_calc u_vref (
    .clk           (clk),
    .arst_n        (arst_n),
    .trim_word     (trim_q),
    .mrg_high_word (mrg_high_q),
    .mrg_low_word  (mrg_low_q),
    .margin        (margin),
    .ref_mv_q      (feedback_node_ref_mv),
    .clamp_hit_q   (clamp_hit)
  );

  property p_pin_only;
    @(posedge clk) disable iff (!arst_n)
      (strap_done && on_off_q[3:2] == 2'b01) |=> (regulate_en_q == (($past(enable_pin)) == $past(on_off_q[1])));
  endproperty
  a_pin_only: assert property (p_pin_only) else $error("pin-only mode not following pin"); // [R1]

  property p_polarity_flip;
    @(posedge clk) disable iff (!arst_n)
      (strap_done && $past(strap_done) && on_off_q[3:2] == 2'b01 && $stable(on_off_q) && $changed(enable_pin))
        |=> $changed(regulate_en_q);
  endproperty
  a_polarity_flip: assert property (p_polarity_flip) else $error("pin edge did not move enable"); // [R2]

  property p_cmd_only;
    @(posedge clk) disable iff (!arst_n)
      (strap_done && on_off_q[3:2] == 2'b10) |=> (regulate_en_q == $past(operation_q[7]));
  endproperty
  a_cmd_only: assert property (p_cmd_only) else $error("command-only mode not following command"); // [R3]

  property p_both;
    @(posedge clk) disable iff (!arst_n)
      (on_off_q[3:2] == 2'b11 && (!operation_q[7] || enable_pin != on_off_q[1])) |=> !regulate_en_q;
  endproperty
  a_both: assert property (p_both) else $error("combined mode on without both"); // [R4]

  property p_mode_read;
    @(posedge clk) disable iff (!arst_n)
      (psel && !penable && !pwrite && paddr == 12'h080) ##1 (psel && penable) |-> (prdata == 32'h0000_0017);
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("format query read wrong"); // [R16]

  property p_op_byte;
    @(posedge clk) disable iff (!arst_n)
      (psel && penable && pwrite && paddr == 12'h004 && pstrb[0]) |=> (operation_q == $past(pwdata[7:0]));
  endproperty
  a_op_byte: assert property (p_op_byte) else $error("operation byte not stored"); // [R17]

  property p_cfg_byte;
    @(posedge clk) disable iff (!arst_n)
      (psel && penable && pwrite && paddr == 12'h008 && pstrb[0]) |=> (on_off_q == $past(pwdata[7:0]));
  endproperty
  a_cfg_byte: assert property (p_cfg_byte) else $error("on/off config byte not stored"); // [R18]

  property p_margin_sel;
    @(posedge clk) disable iff (!arst_n)
      (operation_q[5:4] == 2'b10) |-> (margin == pevc_pkg::pevc_mrg_high);
  endproperty
  a_margin_sel: assert property (p_margin_sel) else $error("margin high not selected"); // [R13]

  property p_always_on;
    @(posedge clk) disable iff (!arst_n)
      (strap_done && on_off_q[3:2] == 2'b00) |=> regulate_en_q;
  endproperty
  a_always_on: assert property (p_always_on) else $error("unconditional mode not enabled");

  property p_both_on;
    @(posedge clk) disable iff (!arst_n)
      (strap_done && on_off_q[3:2] == 2'b11 && operation_q[7] && enable_pin == on_off_q[1]) |=> regulate_en_q;
  endproperty
  a_both_on: assert property (p_both_on) else $error("combined mode off with both on"); // [R4]

  property p_cmd_ignores_pin;
    @(posedge clk) disable iff (!arst_n)
      (strap_done && $past(strap_done) && on_off_q[3:2] == 2'b10 && $stable(on_off_q) && $stable(operation_q))
        |=> $stable(regulate_en_q);
  endproperty
  a_cmd_ignores_pin: assert property (p_cmd_ignores_pin) else $error("command-only mode moved by pin"); // [R3]

  property p_pin_ignores_cmd;
    @(posedge clk) disable iff (!arst_n)
      (strap_done && $past(strap_done) && on_off_q[3:2] == 2'b01 && $stable(on_off_q) && $stable(enable_pin))
        |=> $stable(regulate_en_q);
  endproperty
  a_pin_ignores_cmd: assert property (p_pin_ignores_cmd) else $error("pin-only mode moved by command"); // [R1]

  property p_en_wait_straps;
    @(posedge clk) disable iff (!arst_n)
      !strap_done |=> !regulate_en_q;
  endproperty
  a_en_wait_straps: assert property (p_en_wait_straps) else $error("enabled before straps sampled");

  property p_margin_low_sel;
    @(posedge clk) disable iff (!arst_n)
      (operation_q[5:4] == 2'b01) |-> (margin == pevc_pkg::pevc_mrg_low);
  endproperty
  a_margin_low_sel: assert property (p_margin_low_sel) else $error("margin low not selected"); // [R13]

  property p_op_hold;
    @(posedge clk) disable iff (!arst_n)
      !(psel && penable && pwrite && paddr == 12'h004 && pstrb[0]) |=> $stable(operation_q);
  endproperty
  a_op_hold: assert property (p_op_hold) else $error("operation byte changed without write"); // [R17]

  property p_cfg_hold;
    @(posedge clk) disable iff (!arst_n)
      !(psel && penable && pwrite && paddr == 12'h008 && pstrb[0]) |=> $stable(on_off_q);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("on/off config changed without write"); // [R18]

  property p_unmapped_read;
    @(posedge clk) disable iff (!arst_n)
      (psel && !penable && !pwrite && !mapped(paddr)) ##1 (psel && penable) |-> (prdata == 32'h0000_0000) && pslverr;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not refused");

  property p_status_read;
    @(posedge clk) disable iff (!arst_n)
      (psel && !penable && !pwrite && paddr == 12'h10c) ##1 (psel && penable)
        |-> (prdata[31:16] == $past(feedback_node_ref_mv)) && (prdata[9:3] == $past(bus_address));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status word fields misplaced"); // [R12]

endmodule

// *** tb/pevc_apb_host.sv ***
// apb host model that drives the block's register bus
`timescale 1ns/1ps
module pevc_apb_host (
  // clock
  input  wire logic        clk,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end

  // one transfer, entered right after a rising edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data lines show a changing pattern
    pwdata <= ~d;
    // one idle edge so a following call never reassigns psel in this step
    @(posedge clk);
  endtask
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the enable, address and reference block
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0]  pstrb;
  logic        enable_pin = 1'b0;
  logic [3:0]  lo_d = 4'h0;
  logic [3:0]  hi_d = 4'h0;
  logic        regulate_en_q, bus_fast_ok, err;
  logic [15:0] ref_mv;
  logic [6:0]  bus_address;
  int          bad_count = 0;
  int          checks = 0;
  int          cyc = 0;

  always #4 clk = ~clk;

  pevc_apb_host u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .prdata(prdata));
  pevc_top u_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .enable_pin(enable_pin),
    .addr_strap_low_digit(lo_d), .addr_strap_high_digit(hi_d),
    .regulate_en_q(regulate_en_q), .feedback_node_ref_mv(ref_mv),
    .bus_address(bus_address), .bus_fast_ok(bus_fast_ok));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rdv, err);
  endtask

  task automatic rst(input logic [3:0] l, input logic [3:0] h);
    arst_n <= 1'b0;
    lo_d <= l;
    hi_d <= h;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  function automatic int trim_mv(input logic [15:0] w);
    int t;
    t = (int'($signed(w)) * 1000) >>> 9;
    t = (t < -120) ? -120 : (t > 60) ? 60 : t;
    return (t < 0) ? -(((-t) / 2) * 2) : (t / 2) * 2;
  endfunction

  function automatic int lin11_mv(input logic [15:0] w);
    int e;
    int m;
    e = int'($signed(w[15:11]));
    m = int'($signed(w[10:0])) * 1000;
    return (e < 0) ? (m >>> (-e)) : (m <<< e);
  endfunction

  function automatic int exp_ref(input logic [15:0] t, input logic [15:0] mh,
                                 input logic [15:0] ml, input logic [1:0] mc);
    int s;
    s = trim_mv(t) + ((mc == 2'b10) ? lin11_mv(mh) : (mc == 2'b01) ? lin11_mv(ml) : 0);
    s = (s < -180) ? -180 : (s > 60) ? 60 : s;
    return 600 + s;
  endfunction

  logic [3:0]  sl [4] = '{4'h7, 4'h0, 4'h8, 4'h2};
  logic [3:0]  sh [4] = '{4'h7, 4'h0, 4'h3, 4'hf};
  logic [15:0] mtab [5] = '{16'hbf40, 16'hbfc0, 16'hb800, 16'hb840, 16'hb880};
  logic [15:0] t, mh, ml;
  logic [1:0]  mc;
  logic        on, exp_en;

  initial begin
    void'($urandom(37));
    rst(4'h3, 4'h5);
    chk(bus_address, 32'h2b, "strap address");
    chk(bus_fast_ok, 1, "fast bus");
    chk(ref_mv, 600, "reset reference");
    u_host.xfer(1'b0, 12'h004, 0, rdv, err);
    chk(rdv, 32'h00, "operation reset");
    u_host.xfer(1'b0, 12'h008, 0, rdv, err);
    chk(rdv, 32'h16, "on/off reset");
    wr(12'h080, 32'h55);
    u_host.xfer(1'b0, 12'h080, 0, rdv, err);
    chk(rdv, 32'h17, "format query");
    u_host.xfer(1'b0, 12'h0fc, 0, rdv, err);
    chk({rdv[30:0], err}, 1, "unmapped read");
    $display("test registers done");

    for (int i = 0; i < 8; i++) begin
      t[3:0] = (i < 4) ? sl[i] : 4'($urandom % 16);
      t[7:4] = (i < 4) ? sh[i] : 4'($urandom % 16);
      rst(t[3:0], t[7:4]);
      chk(bus_address, (t[3:0] > 7 || t[7:4] > 7) ? 127 : t[7:4] * 8 + t[3:0], "address");
    end
    $display("test straps done");

    for (int i = 0; i < 32; i++) begin
      on = 1'($urandom);
      wr(12'h008, {28'h1, 2'(i / 8), 1'((i / 4) % 2), 1'b0});
      wr(12'h004, {24'h0, on, 7'h0});
      enable_pin <= 1'($urandom);
      repeat (3) @(posedge clk);
      case (i / 8)
        0: exp_en = 1'b1;
        1: exp_en = (enable_pin == 1'((i / 4) % 2));
        2: exp_en = on;
        default: exp_en = on && (enable_pin == 1'((i / 4) % 2));
      endcase
      chk(regulate_en_q, exp_en, "enable mode");
    end
    $display("test enable done");

    for (int i = 0; i < 24; i++) begin
      t = (i == 0) ? 16'h7fff : (i == 1) ? 16'h8000 : 16'($signed(int'($urandom % 601) - 300));
      mh = mtab[$urandom % 5];
      ml = mtab[$urandom % 5];
      mc = 2'(i % 4);
      wr(12'h100, {16'h0, t});
      wr(12'h104, {16'h0, mh});
      wr(12'h108, {16'h0, ml});
      wr(12'h004, {24'h0, 2'b10, mc, 4'h0});
      repeat (3) @(posedge clk);
      chk(ref_mv, exp_ref(t, mh, ml, mc), "reference");
      u_host.xfer(1'b0, 12'h10c, 0, rdv, err);
      chk(rdv[31:16], exp_ref(t, mh, ml, mc), "status reference");
    end
    $display("test reference done");
    end_of_test();
  end
endmodule
